/* File: hdl/flash_protection_controller.sv */
// Purpose: Flash command and protection controller for the on-chip program array.
// Assumes: Core writes registers with one-cycle strobes; sys_clk is 200 MHz.
// Notes:   Protection is copied from the array only in the load phase after reset.
`timescale 1ns/1ps
`include "flash_prot_defs.svh"

// Functional notes
// - Erased storage means nothing is locked.
// - Protection acts only with last page locked.
// - Settings and key take effect after reset.
// - Active locks cleared only by mass erase.
// - Protection bits only programmable one to zero.
// - Locked last page reads only protection bytes.
// - Active key must match for protection program.
// - Protection key byte lives at F7EB.
// - Last page lock is bit 3 of F7FF.
// - Busy times model write, erases and read.
// - Page erase 512 bytes, erase all whole array.
// - Command write stalls core until done.
// - Interrupts held off while operation runs.
// - Download mode if strap pin low.
// - Download mode honours read and write locks.
// - Download mode refuses protection programming.
// - Emulator commands only in download mode.
// - Emulator load puts data into R0.
// - Emulator store writes R0 to register.
// - Commands need access key 3Bh first.
// - Decode write, erases, read, protection program.
// - Protection key register clears on program.
// - Stored key FFh skips key comparison.
module flash_protection_controller #(
  parameter logic [31:0] WRITE_CYCLES = 32'(`WRITE_CYC),    // Byte write busy time.
  parameter logic [31:0] PAGE_CYCLES  = 32'(`PAGE_CYC),     // Page erase busy time.
  parameter logic [31:0] ALL_CYCLES   = 32'(`ALL_CYC)       // Mass erase busy time.
) (
  input  wire logic                      sys_clk,           // Core clock.
  input  wire logic                      nrst,              // Asynchronous reset, low.
  input  wire flash_prot_pkg::sfr_req_t  sfr,               // Register write from core.
  input  wire logic [7:0]                sfr_raddr,         // Register read address.
  output logic [7:0]                     sfr_rdata,         // Registered read data.
  input  wire logic                      download_enable_n, // Download strap pin, low.
  input  wire flash_prot_pkg::emu_req_t  emu,               // Emulator command.
  output logic                           core_stall,        // Holds core next instruction.
  output logic                           irq_hold,          // Holds interrupt servicing.
  output logic                           dl_mode            // Download mode, registered.
);
  import flash_prot_pkg::*;

  localparam logic [31:0] READ_CYCLES = 32'(`READ_CYC);

  logic [7:0]   mem [0:`FLASH_BYTES-1];
  ctrl_state_t  state_q;
  logic [1:0]   settle_q;
  logic [2:0]   strap_q;
  logic         dl_q;
  logic         act_en_q;
  logic [`WP_PAGES-1:0]  act_wp_q;
  logic [`RP_GROUPS-1:0] act_rp_q;
  logic [7:0]   act_key_q;
  logic [7:0]   cmd_q, akey_q, pkey_q, data_q, addrl_q, addrh_q, r0_q, rdata_q;
  logic [31:0]  cnt_q;
  logic [15:0]  ptr_q, end_q;

  // The array powers up in its factory erased state.
  initial begin
    for (int i = 0; i < int'(`FLASH_BYTES); i++) begin
      mem[i] = `ERASED_BYTE;
    end
  end

  // Page of an array address.
  function automatic logic [6:0] page_of(input logic [15:0] a);
    page_of = a[15:9];
  endfunction

  // Page may not be written or erased under the active setting.
  function automatic logic wlocked(input logic [6:0] p, input logic en,
                                   input logic [`WP_PAGES-1:0] wp);
    wlocked = en && (p < 7'(`WP_PAGES)) && !wp[p];
  endfunction

  // Page belongs to a read-locked group under the active setting.
  function automatic logic rlocked(input logic [6:0] p, input logic en,
                                   input logic [`RP_GROUPS-1:0] rp);
    rlocked = en && (p[6:2] < 5'(`RP_GROUPS)) && !rp[p[6:2]];
  endfunction

  // Write decode: core writes are held off while busy, emulator stores are not.
  wire        emu_ok    = emu.valid && dl_q && state_q != ST_LOAD;
  wire        emu_load  = emu_ok && emu.code == EMU_LOAD_R0;
  wire        emu_store = emu_ok && emu.code == EMU_STORE_R0;
  wire        core_wr   = sfr.wr && state_q == ST_IDLE;
  wire        wr_en     = core_wr || emu_store;
  wire [7:0]  wr_addr   = emu_store ? emu.data : sfr.addr;
  wire [7:0]  wr_data   = emu_store ? r0_q : sfr.wdata;
  wire        issue     = wr_en && wr_addr == `REG_CMD && state_q == ST_IDLE;
  wire [15:0] faddr     = {addrh_q, addrl_q};
  wire [15:0] paddr     = {8'hf7, addrl_q};
  wire [6:0]  fpage     = page_of(faddr);
  wire        in_array  = faddr < `FLASH_BYTES;
  wire        key_ok    = akey_q == `ACCESS_KEY_VAL;
  wire        cur_wlock = wlocked(fpage, act_en_q, act_wp_q);
  wire        cur_rlock = rlocked(fpage, act_en_q, act_rp_q);
  wire        any_wlock = act_en_q && (act_wp_q != '1);
  wire        pkey_ok   = !act_en_q || act_key_q == `KEY_UNUSED || pkey_q == act_key_q;

  // Acceptance of each command; anything refused leaves no trace but the access key clear, the protection key clear on a protection command, and the code in cmd_q.
  logic       cmd_ok;
  always_comb begin
    unique case (wr_data)
      CMD_WRITE:     cmd_ok = faddr < `KEY_ADDR && !cur_wlock;
      CMD_ERASE_PG:  cmd_ok = in_array && !cur_wlock;
      CMD_ERASE_ALL: cmd_ok = !(dl_q && any_wlock);
      CMD_READ:      cmd_ok = in_array && !(dl_q && cur_rlock);
      CMD_PROT:      cmd_ok = !dl_q && addrl_q >= `KEY_ADDR_LO && pkey_ok;
      default:       cmd_ok = 1'b0;
    endcase
  end
  wire go = issue && key_ok && cmd_ok;

  // A locked last page hides everything but its protection bytes from user code.
  wire        hide_rd = !dl_q && cur_rlock && fpage == `LAST_PAGE && faddr < `KEY_ADDR;
  wire [31:0] go_cycles = (wr_data == CMD_WRITE)    ? WRITE_CYCLES :
                          (wr_data == CMD_ERASE_PG) ? PAGE_CYCLES  :
                          (wr_data == CMD_ERASE_ALL) ? ALL_CYCLES  :
                          (wr_data == CMD_PROT)     ? WRITE_CYCLES : READ_CYCLES;
  wire        done = state_q == ST_BUSY && cnt_q == 32'h0 && ptr_q == end_q;

  assign core_stall = state_q != ST_IDLE;
  assign irq_hold   = core_stall;
  assign sfr_rdata  = rdata_q;
  assign dl_mode    = dl_q;

  // Strap pin passes three flops; the settle count covers the pipeline fill.
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      strap_q  <= 3'h7;
      settle_q <= 2'h0;
    end else begin
      strap_q  <= {strap_q[1:0], download_enable_n};
      settle_q <= (settle_q == `STRAP_SETTLE) ? settle_q : settle_q + 2'h1;
    end
  end

  // Controller state: load protection once, then idle and busy.
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      state_q <= ST_LOAD;
      cnt_q   <= 32'h0;
    end else begin
      unique case (state_q)
        ST_LOAD: if (settle_q == `STRAP_SETTLE && strap_q[1] == strap_q[2]) begin
          state_q <= ST_IDLE;
        end
        ST_IDLE: if (go) begin
          state_q <= ST_BUSY;
          cnt_q   <= go_cycles - 32'h1;
        end
        ST_BUSY: begin
          if (cnt_q != 32'h0) begin
            cnt_q <= cnt_q - 32'h1;
          end
          if (done) begin
            state_q <= ST_IDLE;
          end
        end
      endcase
    end
  end

  // Active protection is a snapshot taken only while loading after reset.
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      dl_q      <= 1'b0;
      act_en_q  <= 1'b0;
      act_wp_q  <= '1;
      act_rp_q  <= '1;
      act_key_q <= `KEY_UNUSED;
    end else if (state_q == ST_LOAD) begin
      dl_q      <= !strap_q[2];
      act_en_q  <= !mem[`LAST_PROT_ADDR][`LAST_WP_BIT];
      act_key_q <= mem[`KEY_ADDR];
      for (int i = 0; i < `WP_PAGES; i++) begin
        act_wp_q[i] <= mem[`WP_BASE + 16'(i / 8)][i % 8];
      end
      for (int g = 0; g < `RP_GROUPS; g++) begin
        act_rp_q[g] <= mem[`RP_BASE + 16'(g / 8)][g % 8];
      end
    end
  end

  // Register file with command side effects; emulator stores land here too.
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      cmd_q   <= 8'h00;
      akey_q  <= 8'h00;
      pkey_q  <= `PROT_KEY_RST;
      data_q  <= 8'h00;
      addrl_q <= 8'h00;
      addrh_q <= 8'h00;
      r0_q    <= 8'h00;
    end else begin
      if (emu_load) begin
        r0_q <= emu.data;
      end
      if (wr_en) begin
        unique case (wr_addr)
          `REG_ACCESS_KEY: akey_q  <= wr_data;
          `REG_PROT_KEY:   pkey_q  <= wr_data;
          `REG_DATA:       data_q  <= wr_data;
          `REG_ADDR_LO:    addrl_q <= wr_data;
          `REG_ADDR_HI:    addrh_q <= wr_data;
          default:         ;
        endcase
      end
      // The access key is single use, so a stray command after one is refused.
      if (issue) begin
        cmd_q  <= wr_data;
        akey_q <= 8'h00;
        if (wr_data == CMD_PROT) begin
          pkey_q <= 8'h00;
        end
      end
      if (go && wr_data == CMD_READ) begin
        data_q <= hide_rd ? `LOCKED_READ_VAL : mem[faddr];
      end
    end
  end

  // Erase range is walked one byte per cycle, well inside the busy time.
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      ptr_q <= 16'h0;
      end_q <= 16'h0;
    end else if (go && wr_data == CMD_ERASE_PG) begin
      ptr_q <= {fpage, 9'h0};
      end_q <= {fpage, 9'h0} + `PAGE_BYTES;
    end else if (go && wr_data == CMD_ERASE_ALL) begin
      ptr_q <= 16'h0;
      end_q <= `FLASH_BYTES;
    end else if (ptr_q != end_q) begin
      ptr_q <= ptr_q + 16'h1;
    end
  end

  // Array writes: flash can only clear bits, so programming ANDs into the cell.
  // A plain clocked process, because the power-up fill also writes the array.
  always @(posedge sys_clk) begin
    if (go && wr_data == CMD_WRITE) begin
      mem[faddr] <= mem[faddr] & data_q;
    end else if (go && wr_data == CMD_PROT) begin
      mem[paddr] <= mem[paddr] & data_q;
    end else if (ptr_q != end_q) begin
      mem[ptr_q] <= `ERASED_BYTE;
    end
  end

  // Read mux is registered so the data port comes from a flop.
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      rdata_q <= 8'h00;
    end else begin
      unique case (sfr_raddr)
        `REG_CMD:        rdata_q <= cmd_q;
        `REG_ACCESS_KEY: rdata_q <= akey_q;
        `REG_PROT_KEY:   rdata_q <= pkey_q;
        `REG_DATA:       rdata_q <= data_q;
        `REG_ADDR_LO:    rdata_q <= addrl_q;
        `REG_ADDR_HI:    rdata_q <= addrh_q;
        default:         rdata_q <= 8'h00;
      endcase
    end
  end

  // Stall cycles since the last accepted read; a counter replaces a long repetition.
  logic       rd_run_q;
  logic [5:0] rd_len_q;
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      rd_run_q <= 1'b0;
      rd_len_q <= 6'h00;
    end else if (go && wr_data == CMD_READ) begin
      rd_run_q <= 1'b1;
      rd_len_q <= 6'h00;
    end else if (rd_run_q && core_stall) begin
      rd_len_q <= rd_len_q + 6'h01;
    end else begin
      rd_run_q <= 1'b0;
    end
  end

  // Checks on the controller's own behaviour.
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!nrst);

  no_lock_a: assert property (!act_en_q |-> !cur_wlock && !cur_rlock)
    else $error("page locked while protection inactive");
  enable_bit_a: assert property (state_q == ST_LOAD ##1 state_q == ST_IDLE
      |-> act_en_q == !$past(mem[`LAST_PROT_ADDR][`LAST_WP_BIT]))
    else $error("enable does not follow last page lock bit");
  snap_stable_a: assert property (state_q != ST_LOAD |=> $stable(act_wp_q) && $stable(act_key_q))
    else $error("active protection changed without reset");
  lock_refuse_a: assert property (issue && key_ok && wr_data == CMD_ERASE_PG && cur_wlock
      |=> state_q == ST_IDLE)
    else $error("locked page erase was not refused");
  prot_key_a: assert property (go && wr_data == CMD_PROT
      |-> !act_en_q || act_key_q == `KEY_UNUSED || pkey_q == act_key_q)
    else $error("protection program with wrong key");
  access_key_a: assert property (go |-> akey_q == `ACCESS_KEY_VAL)
    else $error("command run without access key");
  pkey_clear_a: assert property (issue && wr_data == CMD_PROT |=> pkey_q == 8'h00)
    else $error("protection key register not cleared");
  write_stall_a: assert property (go && wr_data == CMD_WRITE
      |=> core_stall [*8] ##0 irq_hold)
    else $error("write did not stall the core");
  read_time_a: assert property (rd_run_q && !core_stall |-> rd_len_q == 6'(READ_CYCLES))
    else $error("read busy time wrong");
  dl_refuse_a: assert property (go |-> !(dl_q && (wr_data == CMD_PROT ||
      (wr_data == CMD_READ && cur_rlock))))
    else $error("download mode allowed a refused command");
  emu_load_a: assert property (emu_load |=> r0_q == $past(emu.data))
    else $error("emulator load did not reach R0");
  emu_gate_a: assert property (emu.valid && !dl_q && !sfr.wr |=> $stable(r0_q) && $stable(data_q))
    else $error("emulator command acted outside download mode");

  write_cov_c:  cover property (go && wr_data == CMD_WRITE ##[1:300] done);
  erase_cov_c:  cover property (go && wr_data == CMD_ERASE_PG);
  prot_cov_c:   cover property (go && wr_data == CMD_PROT && act_en_q);
  store_cov_c:  cover property (emu_store && emu.data == `REG_CMD);

endmodule

/* File: hdl/flash_prot_defs.svh */
// Purpose: Offsets, field positions, reset values and timing counts for the flash controller.
// Assumes: Core clock of 200 MHz, byte-wide special function registers.
// Notes:   Definitions only; included by the controller, the core model and the bench.
`ifndef FLASH_PROT_DEFS_SVH
`define FLASH_PROT_DEFS_SVH

// Special function register addresses.
`define REG_CMD          8'hb9
`define REG_ACCESS_KEY   8'hba
`define REG_PROT_KEY     8'hbb
`define REG_DATA         8'hbc
`define REG_ADDR_LO      8'hc6
`define REG_ADDR_HI      8'hc7

// Array geometry and protection area layout.
`define FLASH_BYTES      16'hf800
`define PAGE_BYTES       16'h0200
`define LAST_PAGE        7'h7b
`define KEY_ADDR         16'hf7eb
`define KEY_ADDR_LO      8'heb
`define RP_BASE          16'hf7ec
`define WP_BASE          16'hf7f0
`define LAST_PROT_ADDR   16'hf7ff
`define LAST_WP_BIT      3
`define RP_GROUPS        31
`define WP_PAGES         124

// Key and reset values.
`define ACCESS_KEY_VAL   8'h3b
`define KEY_UNUSED       8'hff
`define ERASED_BYTE      8'hff
`define PROT_KEY_RST     8'hff
`define LOCKED_READ_VAL  8'h00

// Timing, each figure in its own unit, then converted to whole cycles.
`define CLK_PERIOD_PS    64'd5000
`define T_WRITE_US       64'd30
`define T_PAGE_MS        64'd20
`define T_ALL_MS         64'd2500
`define T_READ_NS        64'd100
`define CYC(ps)          (((ps) + `CLK_PERIOD_PS - 64'd1) / `CLK_PERIOD_PS)
`define WRITE_CYC        `CYC(`T_WRITE_US * 64'd1000000)
`define PAGE_CYC         `CYC(`T_PAGE_MS * 64'd1000000000)
`define ALL_CYC          `CYC(`T_ALL_MS * 64'd1000000000)
`define READ_CYC         `CYC(`T_READ_NS * 64'd1000)
`define STRAP_SETTLE     2'h3

`endif

/* File: hdl/flash_prot_pkg.sv */
// Purpose: Types shared by the flash controller and its users.
// Assumes: Constants come from flash_prot_defs.svh.
// Notes:   Holds command codes, controller states and the port structs.
package flash_prot_pkg;

  // Command codes written to the command register.
  typedef enum logic [7:0] {
    CMD_WRITE     = 8'h01,
    CMD_ERASE_PG  = 8'h02,
    CMD_ERASE_ALL = 8'h03,
    CMD_READ      = 8'h04,
    CMD_PROT      = 8'h08
  } flash_cmd_t;

  // Emulator command codes accepted in download mode.
  typedef enum logic [7:0] {
    EMU_LOAD_R0  = 8'h49,
    EMU_STORE_R0 = 8'h46
  } emu_cmd_t;

  typedef enum logic [1:0] {ST_LOAD, ST_IDLE, ST_BUSY} ctrl_state_t;

  // One register write from the core.
  typedef struct packed {
    logic       wr;
    logic [7:0] addr;
    logic [7:0] wdata;
  } sfr_req_t;

  // One emulator command from the download kernel.
  typedef struct packed {
    logic       valid;
    logic [7:0] code;
    logic [7:0] data;
  } emu_req_t;

endpackage

/* File: verification/core_model.sv */
// Purpose: Core model that writes controller registers and issues flash and emulator commands.
// Assumes: Requests change at the falling edge and are taken at the following rising edge.
// Notes:   Every wait for idle is bounded; a stall that never ends raises hang.
`timescale 1ns/1ps
`include "flash_prot_defs.svh"
module core_model (
  input  wire logic                sys_clk,    // Core clock.
  input  wire logic                core_stall, // Stall from the controller.
  output flash_prot_pkg::sfr_req_t sfr,        // Register write.
  output flash_prot_pkg::emu_req_t emu,        // Emulator command.
  output logic                     hang        // Stall never ended.
);
  import flash_prot_pkg::*;

  // Nothing is requested until the bench asks.
  initial begin
    sfr  = '0;
    emu  = '0;
    hang = 1'b0;
  end

  // A write made while stalled is dropped, so each register write waits for idle first.
  task automatic wait_idle();
    int n;
    n = 0;
    while (core_stall !== 1'b0 && n < 80000) begin
      @(negedge sys_clk);
      n++;
    end
    if (n >= 80000) hang = 1'b1;
  endtask

  // One register write, held for exactly one rising edge.
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge sys_clk);
    wait_idle();
    sfr = '{1'b1, a, d};
    @(negedge sys_clk);
    sfr.wr = 1'b0;
  endtask

  // The access key goes in just before every command code.
  task automatic flash_op(input logic [7:0] cmd, input logic [7:0] hi, input logic [7:0] lo,
                          input logic [7:0] d);
    wr(`REG_DATA, d);
    wr(`REG_ADDR_HI, hi);
    wr(`REG_ADDR_LO, lo);
    wr(`REG_ACCESS_KEY, `ACCESS_KEY_VAL);
    wr(`REG_CMD, cmd);
  endtask

  // One emulator command strobe.
  task automatic emu_op(input logic [7:0] code, input logic [7:0] d);
    @(negedge sys_clk);
    emu = '{1'b1, code, d};
    @(negedge sys_clk);
    emu.valid = 1'b0;
  endtask

  // A register write in download mode is a load followed by a store.
  task automatic emu_wr(input logic [7:0] a, input logic [7:0] d);
    emu_op(EMU_LOAD_R0, d);
    emu_op(EMU_STORE_R0, a);
  endtask
endmodule

/* File: verification/test_flash_protection_controller.sv */
// Purpose: Self-checking bench for the flash protection controller.
// Assumes: Write and erase busy counts are shortened by parameters; the array starts erased.
// Notes:   Read results are noted in a queue and compared by a separate monitor.
`timescale 1ns/1ps
`include "flash_prot_defs.svh"
module test_flash_protection_controller;
  import flash_prot_pkg::*;
  localparam int WR_CYC = 10;
  localparam logic [7:0] KEY = 8'ha5;
  logic                     sys_clk;
  logic                     nrst;
  logic [7:0]               sfr_raddr;
  logic [7:0]               sfr_rdata;
  logic                     download_enable_n;
  logic                     core_stall;
  logic                     irq_hold;
  logic                     dl_mode;
  logic                     hang;
  logic                     chk_en;
  sfr_req_t                 sfr;
  emu_req_t                 emu;
  logic [7:0]               exp_q[$];
  int                       mismatches;
  int                       n_checks;
  logic [6:0]               pg;
  logic [7:0]               hi;
  logic [7:0]               d1;
  logic [7:0]               d2;
  logic [7:0]               wp_lo;
  int                       n;

  flash_protection_controller #(.WRITE_CYCLES(WR_CYC), .PAGE_CYCLES(600), .ALL_CYCLES(10)) u_dut (
    .sys_clk(sys_clk), .nrst(nrst), .sfr(sfr), .sfr_raddr(sfr_raddr), .sfr_rdata(sfr_rdata),
    .download_enable_n(download_enable_n), .emu(emu), .core_stall(core_stall),
    .irq_hold(irq_hold), .dl_mode(dl_mode));
  core_model u_core (.sys_clk(sys_clk), .core_stall(core_stall), .sfr(sfr), .emu(emu),
    .hang(hang));

  always #2.5 sys_clk = ~sys_clk;

  task automatic give_verdict();
    if (mismatches == 0 && n_checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask

  task automatic check_val(input string name, input logic [31:0] e, input logic [31:0] g);
    n_checks++;
    if (g !== e) begin
      mismatches++;
      $display("MISMATCH %s expected %h seen %h", name, e, g);
    end
  endtask

  task automatic check_byte(input logic [7:0] e, input logic [7:0] g);
    n_checks++;
    if (g !== e) begin
      mismatches++;
      $display("MISMATCH sfr_rdata expected %h seen %h", e, g);
    end
  endtask

  // The monitor takes the oldest note whenever the driver flags a settled read.
  always @(negedge sys_clk) begin
    if (chk_en === 1'b1) check_byte(exp_q.pop_front(), sfr_rdata);
  end

  // A hung stall ends the run as a failure.
  always @(posedge sys_clk) begin
    if (hang === 1'b1) begin
      mismatches++;
      give_verdict();
    end
  end

  // Register read: address, one cycle for the registered data, then flag the monitor.
  task automatic peek(input logic [7:0] a, input logic [7:0] e);
    @(negedge sys_clk);
    sfr_raddr = a;
    exp_q.push_back(e);
    @(negedge sys_clk);
    chk_en <= 1'b1;
    @(negedge sys_clk);
    chk_en <= 1'b0;
  endtask

  task automatic stall_len(output int cnt);
    cnt = 0;
    while (core_stall === 1'b1 && cnt < 80000) begin
      cnt++;
      @(negedge sys_clk);
    end
  endtask

  task automatic read_byte(input logic [7:0] h, input logic [7:0] l, input logic [7:0] e);
    int c;
    u_core.flash_op(CMD_READ, h, l, 8'h00);
    stall_len(c);
    check_val("read_busy", 32'd20, 32'(c));
    peek(`REG_DATA, e);
  endtask

  // Reset for 20 cycles with the strap pin set as asked, then wait out the load phase.
  task automatic do_reset(input logic dl_n);
    @(negedge sys_clk);
    nrst = 1'b0;
    download_enable_n = dl_n;
    repeat (20) @(negedge sys_clk);
    check_val("reset_stall", 32'd1, 32'(core_stall));
    check_val("reset_irq_hold", 32'd1, 32'(irq_hold));
    nrst = 1'b1;
    u_core.wait_idle();
    check_val("dl_mode", 32'(!dl_n), 32'(dl_mode));
  endtask

  task automatic refused_write(input logic [7:0] h, input logic [7:0] l);
    u_core.flash_op(CMD_WRITE, h, l, 8'h00);
    check_val("refused_stall", 32'd0, 32'(core_stall));
  endtask

  initial begin
    sys_clk = 1'b0;
    nrst = 1'b0;
    sfr_raddr = 8'h00;
    download_enable_n = 1'b1;
    chk_en = 1'b0;
    mismatches = 0;
    n_checks = 0;
    void'($urandom(61365));
    do_reset(1'b1);
    // Reset values, and an unmapped place reads zero.
    peek(`REG_PROT_KEY, `PROT_KEY_RST);
    peek(`REG_ACCESS_KEY, 8'h00);
    peek(`REG_ADDR_HI, 8'h00);
    peek(8'h80, 8'h00);
    // Last byte of a random page and first byte of the next one.
    pg = 7'($urandom_range(0, 100));
    hi = {pg, 1'b1};
    d1 = 8'($urandom);
    d2 = 8'($urandom);
    u_core.flash_op(CMD_WRITE, hi, 8'hff, d1);
    check_val("busy_irq_hold", 32'd1, 32'(irq_hold));
    stall_len(n);
    check_val("write_busy", 32'(WR_CYC), 32'(n));
    u_core.flash_op(CMD_WRITE, hi + 8'h01, 8'h00, d2);
    read_byte(hi, 8'hff, d1);
    // Command code without the access key changes only cmd_q and does not stall.
    u_core.wr(`REG_CMD, CMD_WRITE);
    check_val("nokey_stall", 32'd0, 32'(core_stall));
    read_byte(hi, 8'hff, d1);
    u_core.flash_op(CMD_WRITE, hi, 8'hff, d2);
    read_byte(hi, 8'hff, d1 & d2);
    // A page erase clears its own page only.
    u_core.flash_op(CMD_ERASE_PG, hi, 8'hff, 8'h00);
    read_byte(hi, 8'hff, 8'hff);
    read_byte(hi + 8'h01, 8'h00, d2);
    // Lock the page, the last page and set the key; nothing acts before a reset.
    wp_lo = 8'hf0 + 8'(pg >> 3);
    u_core.flash_op(CMD_PROT, 8'h00, wp_lo, ~(8'h01 << pg[2:0]));
    u_core.flash_op(CMD_PROT, 8'h00, 8'hef, 8'hbf);
    u_core.flash_op(CMD_PROT, 8'h00, 8'hff, 8'hf7);
    u_core.flash_op(CMD_PROT, 8'h00, 8'heb, KEY);
    u_core.flash_op(CMD_WRITE, hi, 8'h00, 8'h00);
    read_byte(hi, 8'h00, 8'h00);
    do_reset(1'b1);
    refused_write(hi, 8'h01);
    read_byte(hi, 8'h01, 8'hff);
    u_core.flash_op(CMD_ERASE_PG, hi, 8'h00, 8'h00);
    check_val("erase_refused_stall", 32'd0, 32'(core_stall));
    read_byte(hi, 8'h00, 8'h00);
    read_byte(8'hf7, 8'hff, 8'hf7);
    read_byte(8'hf7, 8'heb, KEY);
    read_byte(8'hf7, 8'hea, `LOCKED_READ_VAL);
    // A wrong key refuses the update; the key register clears on every protection command issue.
    u_core.wr(`REG_PROT_KEY, KEY ^ 8'h01);
    u_core.flash_op(CMD_PROT, 8'h00, 8'hfd, 8'h00);
    read_byte(8'hf7, 8'hfd, 8'hff);
    peek(`REG_PROT_KEY, 8'h00);
    u_core.wr(`REG_PROT_KEY, KEY);
    u_core.flash_op(CMD_PROT, 8'h00, 8'hfd, 8'h0f);
    read_byte(8'hf7, 8'hfd, 8'h0f);
    // Only a mass erase removes active locks.
    u_core.flash_op(CMD_ERASE_ALL, 8'h00, 8'h00, 8'h00);
    u_core.wait_idle();
    do_reset(1'b1);
    u_core.flash_op(CMD_WRITE, hi, 8'h02, d1);
    read_byte(hi, 8'h02, d1);
    read_byte(8'hf7, 8'hff, 8'hff);
    // Download mode: emulator writes act, protection programming is refused.
    do_reset(1'b0);
    u_core.emu_wr(`REG_ADDR_LO, d2);
    peek(`REG_ADDR_LO, d2);
    u_core.emu_wr(`REG_DATA, 8'h00);
    u_core.emu_wr(`REG_ADDR_LO, 8'hf2);
    u_core.emu_wr(`REG_ACCESS_KEY, `ACCESS_KEY_VAL);
    u_core.emu_wr(`REG_CMD, CMD_PROT);
    u_core.wait_idle();
    do_reset(1'b1);
    u_core.emu_wr(`REG_ADDR_LO, d2 | 8'h01);
    peek(`REG_ADDR_LO, 8'h00);
    read_byte(8'hf7, 8'hf2, 8'hff);
    give_verdict();
  end
endmodule
